// *** hdl/cvms_core.sv ***
// Mode and sequencing logic of the core voltage regulator controller.
// Assumes synchronous inputs, 20 MHz clk, a plain register port.
`timescale 1ns/10ps
module cvms_core #(
  parameter int DIS_WAIT   = cvms_pkg::DIS_WAIT_DEF,
  parameter int SKIP_WAIT  = cvms_pkg::SKIP_WAIT_DEF,
  parameter bit OV_DETECT  = 1'b1
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic [cvms_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_write,
  input  wire logic                           reg_read,
  output logic [31:0]                         reg_rdata,
  input  wire logic [cvms_pkg::CODE_W-1:0]    cpu_voltage_code,
  input  wire logic                           suspend_req,
  input  wire logic                           boot_mode,
  input  wire logic                           deep_sleep_req_n,
  input  wire logic [cvms_pkg::CODE_W-1:0]    deep_sleep_offset,
  input  cvms_pkg::cvms_sel_t                 suspend_level_sel,
  input  cvms_pkg::cvms_sel_t                 boot_level_sel,
  input  wire logic                           system_power_good,
  input  wire logic                           shutdown_n,
  input  wire logic                           shutdown_high_voltage,
  input  cvms_pkg::cvms_fault_in_t            fault_in,
  output logic [cvms_pkg::CODE_W-1:0]         voltage_code,
  output logic                                slave_driver_disable_n,
  output logic                                skip_enable,
  output logic                                low_side_gate,
  output logic                                fault_latched,
  output logic                                irq
);

  // ==========================================================
  // Elaboration checks
  generate
    if (DIS_WAIT < 1 || DIS_WAIT > 255 || SKIP_WAIT < 1 || SKIP_WAIT > 255)
    begin : g_bad_wait
      $error("cvms_core: wait counts must lie in 1..255");
    end
  endgenerate

  localparam logic [cvms_pkg::CNT_W-1:0] DIS_LAST  =
    cvms_pkg::CNT_W'(DIS_WAIT - 1);
  localparam logic [cvms_pkg::CNT_W-1:0] SKIP_LAST =
    cvms_pkg::CNT_W'(SKIP_WAIT - 1);

  cvms_pkg::cvms_core_t q;
  cvms_pkg::cvms_core_t next_q;

  logic                          tick;
  logic [cvms_pkg::CODE_W-1:0]   susp_code;
  logic [cvms_pkg::CODE_W-1:0]   boot_code;
  logic [cvms_pkg::CODE_W-1:0]   base_code;
  logic [cvms_pkg::CODE_W-1:0]   run_target;
  logic [cvms_pkg::CODE_W-1:0]   target;
  logic signed [7:0]             sum;
  logic                          deep_sleep;
  logic                          low_power;
  logic                          settled;
  logic                          spg_fall;
  logic [2:0]                    fault_now;
  logic [cvms_pkg::EV_W-1:0]     ev;
  logic [cvms_pkg::DIV_W-1:0]    wdiv;

  // ==========================================================
  // Slew clock and level decoders
  cvms_slew_div u_div (
    .clk     (clk),
    .rst     (rst),
    .divisor (q.slew_div),
    .tick    (tick)
  );

  cvms_level_decode u_susp (
    .sel  (suspend_level_sel),
    .code (susp_code)
  );

  cvms_level_decode u_boot (
    .sel  (boot_level_sel),
    .code (boot_code)
  );

  // ==========================================================
  // Target selection
  always_comb
  begin
    deep_sleep = ~deep_sleep_req_n;
    if (boot_mode)
      base_code = boot_code;
    else if (suspend_req)
      base_code = susp_code;
    else
      base_code = cpu_voltage_code;
    sum = $signed({2'b00, base_code});
    if (deep_sleep)
      sum = sum + $signed({{2{deep_sleep_offset[5]}}, deep_sleep_offset});
    if (sum < 0)
      run_target = '0;
    else if (sum > 8'sd63)
      run_target = '1;
    else
      run_target = sum[cvms_pkg::CODE_W-1:0];
    if (q.mode == cvms_pkg::CVMS_RUN)
      target = run_target;
    else
      target = '0;
  end

  assign settled   = (q.cur_code == target);
  assign low_power = (q.mode == cvms_pkg::CVMS_RUN) && (suspend_req || deep_sleep);
  assign spg_fall  = q.spg_prev & ~system_power_good;

  // Fault sources: power-good, thermal, undervoltage, overvoltage
  always_comb
  begin
    fault_now    = '0;
    fault_now[0] = spg_fall;
    fault_now[1] = fault_in.thermal;
    fault_now[2] = fault_in.under_voltage & ~shutdown_high_voltage;
    if (OV_DETECT)
      fault_now[2] = fault_now[2] |
                     (fault_in.over_voltage & ~shutdown_high_voltage);
  end

  // Clamped divisor written by software
  always_comb
  begin
    wdiv = reg_wdata[cvms_pkg::DIV_W-1:0];
    if (wdiv < cvms_pkg::SLEW_DIV_MIN)
      wdiv = cvms_pkg::SLEW_DIV_MIN;
    else if (wdiv > cvms_pkg::SLEW_DIV_MAX)
      wdiv = cvms_pkg::SLEW_DIV_MAX;
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    next_q          = q;
    ev              = '0;
    next_q.spg_prev = system_power_good;
    next_q.rd_data  = '0;

    // Output slew toward target
    if (tick && !settled)
    begin
      if (q.cur_code < target)
        next_q.cur_code = q.cur_code + 1'b1;
      else
        next_q.cur_code = q.cur_code - 1'b1;
      if (next_q.cur_code == target)
        ev[cvms_pkg::EV_SETTLED] = 1'b1;
    end

    // Mode sequencing
    case (q.mode)
      cvms_pkg::CVMS_OFF:
      begin
        next_q.lsg = 1'b1;
        if (shutdown_n && system_power_good)
        begin
          next_q.mode = cvms_pkg::CVMS_RUN;
          next_q.lsg  = 1'b0;
        end
      end
      cvms_pkg::CVMS_RUN:
      begin
        if (!shutdown_n)
          next_q.mode = cvms_pkg::CVMS_RAMP_DOWN;
      end
      cvms_pkg::CVMS_RAMP_DOWN:
      begin
        if (q.cur_code == '0)
        begin
          next_q.mode = cvms_pkg::CVMS_OFF;
          next_q.lsg  = 1'b1;
        end
        else if (shutdown_n)
        begin
          next_q.mode = cvms_pkg::CVMS_RUN;
        end
      end
      cvms_pkg::CVMS_FAULT:
      begin
        next_q.lsg      = 1'b1;
        next_q.cur_code = '0;
        if (!shutdown_n || shutdown_high_voltage)
        begin
          next_q.fault = 1'b0;
          next_q.mode  = cvms_pkg::CVMS_OFF;
        end
      end
      default:
      begin
        next_q.mode = cvms_pkg::CVMS_OFF;
      end
    endcase

    // Fault latch takes over from any running mode
    if (q.mode != cvms_pkg::CVMS_FAULT && q.mode != cvms_pkg::CVMS_OFF
        && (|fault_now))
    begin
      next_q.mode     = cvms_pkg::CVMS_FAULT;
      next_q.fault    = 1'b1;
      next_q.cause    = fault_now;
      next_q.lsg      = 1'b1;
      next_q.cur_code = '0;
      ev[cvms_pkg::EV_FAULT] = 1'b1;
    end

    // Driver disable and pulse-skip sequence
    if (!low_power || !settled || next_q.mode != cvms_pkg::CVMS_RUN)
    begin
      next_q.dis_n   = 1'b1;
      next_q.skip_en = 1'b0;
      next_q.lp_cnt  = '0;
    end
    else if (tick && q.dis_n)
    begin
      if (q.lp_cnt == DIS_LAST)
      begin
        next_q.dis_n  = 1'b0;
        next_q.lp_cnt = '0;
        ev[cvms_pkg::EV_DIS_LOW] = 1'b1;
      end
      else
      begin
        next_q.lp_cnt = q.lp_cnt + 1'b1;
      end
    end
    else if (tick && !q.skip_en)
    begin
      if (q.lp_cnt == SKIP_LAST)
      begin
        next_q.skip_en = 1'b1;
        ev[cvms_pkg::EV_SKIP_ON] = 1'b1;
      end
      else
      begin
        next_q.lp_cnt = q.lp_cnt + 1'b1;
      end
    end

    // Register writes; a new event wins over its clear
    if (reg_write)
    begin
      case (reg_addr)
        cvms_pkg::OFS_CTRL:
          next_q.slew_div = wdiv;
        cvms_pkg::OFS_STATUS:
          next_q.status = q.status & ~reg_wdata[cvms_pkg::EV_W-1:0];
        cvms_pkg::OFS_MASK:
          next_q.mask = reg_wdata[cvms_pkg::EV_W-1:0];
        default:
          next_q.status = q.status;
      endcase
    end
    next_q.status = next_q.status | ev;
    next_q.irq    = |(next_q.status & next_q.mask);

    // Register reads: data in the following cycle only
    if (reg_read)
    begin
      case (reg_addr)
        cvms_pkg::OFS_CTRL:
          next_q.rd_data[cvms_pkg::DIV_W-1:0] = q.slew_div;
        cvms_pkg::OFS_STATUS:
          next_q.rd_data[cvms_pkg::EV_W-1:0] = q.status;
        cvms_pkg::OFS_MASK:
          next_q.rd_data[cvms_pkg::EV_W-1:0] = q.mask;
        cvms_pkg::OFS_STATE:
        begin
          next_q.rd_data[cvms_pkg::ST_CODE_LSB +: cvms_pkg::CODE_W] = q.cur_code;
          next_q.rd_data[cvms_pkg::ST_DIS_BIT]  = q.dis_n;
          next_q.rd_data[cvms_pkg::ST_SKIP_BIT] = q.skip_en;
          next_q.rd_data[cvms_pkg::ST_LSG_BIT]  = q.lsg;
          next_q.rd_data[cvms_pkg::ST_FLT_BIT]  = q.fault;
          next_q.rd_data[cvms_pkg::ST_CAUSE_LSB +: 3] = q.cause;
          next_q.rd_data[cvms_pkg::ST_MODE_LSB +: 2]  = q.mode;
        end
        default:
          next_q.rd_data = '0;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q          <= '0;
      q.mode     <= cvms_pkg::CVMS_OFF;
      q.dis_n    <= 1'b1;
      q.lsg      <= 1'b1;
      q.slew_div <= cvms_pkg::SLEW_DIV_RST;
      q.mask     <= cvms_pkg::MASK_RST;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata              = q.rd_data;
  assign voltage_code           = q.cur_code;
  assign slave_driver_disable_n = q.dis_n;
  assign skip_enable            = q.skip_en;
  assign low_side_gate          = q.lsg;
  assign fault_latched          = q.fault;
  assign irq                    = q.irq;

endmodule

// *** hdl/cvms_pkg.sv ***
// Constants, carriers and state types of the core voltage mode sequencer.
// Assumes a single 20 MHz clock and synchronous, active-high reset.
package cvms_pkg;

  // ==========================================================
  // Clock and slew timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int SLEW_HZ_MIN  = 64_000;
  localparam int SLEW_HZ_MAX  = 640_000;
  localparam int SLEW_HZ_DEF  = 320_000;
  localparam int DIV_W        = 9;
  localparam logic [DIV_W-1:0] SLEW_DIV_MIN = DIV_W'(CLK_HZ / SLEW_HZ_MAX);
  localparam logic [DIV_W-1:0] SLEW_DIV_MAX = DIV_W'(CLK_HZ / SLEW_HZ_MIN);
  localparam logic [DIV_W-1:0] SLEW_DIV_RST = DIV_W'(CLK_HZ / SLEW_HZ_DEF);
  localparam int DIS_WAIT_DEF  = 32;
  localparam int SKIP_WAIT_DEF = 32;
  localparam int CNT_W         = 8;

  // ==========================================================
  // Codes and register map
  localparam int CODE_W = 6;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATE  = 4'hC;
  localparam int EV_W        = 4;
  localparam int EV_FAULT    = 0;
  localparam int EV_DIS_LOW  = 1;
  localparam int EV_SKIP_ON  = 2;
  localparam int EV_SETTLED  = 3;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  localparam int ST_CODE_LSB = 0;
  localparam int ST_DIS_BIT  = 6;
  localparam int ST_SKIP_BIT = 7;
  localparam int ST_LSG_BIT  = 8;
  localparam int ST_FLT_BIT  = 9;
  localparam int ST_CAUSE_LSB = 10;
  localparam int ST_MODE_LSB  = 13;

  // ==========================================================
  // Carriers and state types
  typedef struct packed {
    logic [1:0] sel2;
    logic [1:0] sel1;
    logic [1:0] sel0;
  } cvms_sel_t;

  typedef struct packed {
    logic over_voltage;
    logic under_voltage;
    logic thermal;
  } cvms_fault_in_t;

  typedef enum logic [1:0] {
    CVMS_OFF,
    CVMS_RUN,
    CVMS_RAMP_DOWN,
    CVMS_FAULT
  } cvms_mode_t;

  typedef struct packed {
    cvms_mode_t        mode;
    logic [CODE_W-1:0] cur_code;
    logic [CNT_W-1:0]  lp_cnt;
    logic              dis_n;
    logic              skip_en;
    logic              lsg;
    logic              fault;
    logic [2:0]        cause;
    logic              spg_prev;
    logic [DIV_W-1:0]  slew_div;
    logic [EV_W-1:0]   status;
    logic [EV_W-1:0]   mask;
    logic              irq;
    logic [31:0]       rd_data;
  } cvms_core_t;

endpackage

// *** hdl/cvms_level_decode.sv ***
// Combines three pre-decoded four-level selection inputs into a target code.
// Assumes each input has already been resolved to a 2-bit level.
`timescale 1ns/10ps
module cvms_level_decode #(
  parameter logic [cvms_pkg::CODE_W-1:0] LEVEL_BASE = 6'h00
) (
  input  cvms_pkg::cvms_sel_t              sel,
  output logic [cvms_pkg::CODE_W-1:0]      code
);

  // ==========================================================
  // Target code is the packed level index plus LEVEL_BASE
  logic [cvms_pkg::CODE_W-1:0] index;
  logic [2:0][1:0]             levels;

  assign levels = {sel.sel2, sel.sel1, sel.sel0};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_lvl
      assign index[2*g +: 2] = levels[g];
    end
  endgenerate

  assign code = index + LEVEL_BASE;

endmodule

// *** hdl/cvms_slew_div.sv ***
// Slew clock divider: one-cycle enable pulse every divisor clocks.
// Assumes the divisor is already held within the legal range.
`timescale 1ns/10ps
module cvms_slew_div (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [cvms_pkg::DIV_W-1:0]   divisor,
  output logic                              tick
);

  typedef struct packed {
    logic [cvms_pkg::DIV_W-1:0] cnt;
    logic                       tick;
  } cvms_div_t;

  cvms_div_t q;
  cvms_div_t next_q;

  // ==========================================================
  // Count and pulse
  always_comb
  begin
    next_q      = q;
    next_q.tick = 1'b0;
    if (q.cnt >= divisor - 1'b1)
    begin
      next_q.cnt  = '0;
      next_q.tick = 1'b1;
    end
    else
    begin
      next_q.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= next_q;
  end

  assign tick = q.tick;

endmodule

// *** bench/cvms_core_properties.sv ***
// Port checks of the voltage mode sequencer, bound into cvms_core.
// Assumes the slew divisor never goes below its minimum.
`timescale 1ns/10ps
module cvms_core_properties #(
  parameter int SKIP_WAIT = 32,
  parameter bit OV_DETECT = 1'b1
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     system_power_good,
  input wire logic                     shutdown_n,
  input wire logic                     shutdown_high_voltage,
  input cvms_pkg::cvms_fault_in_t      fault_in,
  input wire logic [5:0]               voltage_code,
  input wire logic                     slave_driver_disable_n,
  input wire logic                     skip_enable,
  input wire logic                     low_side_gate,
  input wire logic                     fault_latched
);
  // ==========
  // Cycles with driver disable low
  logic [15:0] low_cnt;
  always_ff @(posedge clk)
  begin
    if (rst || slave_driver_disable_n)
      low_cnt <= 16'h0000;
    else if (low_cnt != 16'hFFFF)
      low_cnt <= low_cnt + 16'h0001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ==========
  // Assertions
  AST_LSG_FAULT: assert property (fault_latched |-> low_side_gate)
    else $error("low side gate low while faulted");
  AST_PG_FALL: assert property ($fell(system_power_good) && !low_side_gate
    |=> fault_latched && voltage_code == 6'h00) else $error("no fault on power good fall");
  AST_FAULT_HOLD: assert property (fault_latched && shutdown_n && !shutdown_high_voltage
    |=> fault_latched) else $error("fault latch lost");
  AST_FAULT_CLR: assert property (fault_latched && (!shutdown_n || shutdown_high_voltage)
    |=> !fault_latched) else $error("fault latch not cleared");
  AST_THERMAL: assert property (!low_side_gate && fault_in.thermal |=> fault_latched)
    else $error("thermal fault missed");
  AST_OV: assert property (!low_side_gate && fault_in.over_voltage && !shutdown_high_voltage
    |=> fault_latched == OV_DETECT) else $error("overvoltage handling wrong");
  AST_STEP: assert property ($changed(voltage_code) && !fault_latched
    |-> 6'(voltage_code - $past(voltage_code)) inside {6'h01, 6'h3F})
    else $error("code step larger than one");
  AST_SPACING: assert property ($changed(voltage_code) && !fault_latched
    |=> ($stable(voltage_code) || fault_latched) [*8]) else $error("steps too close");
  AST_SKIP_WAIT: assert property ($rose(skip_enable)
    |-> int'(low_cnt) >= SKIP_WAIT * int'(cvms_pkg::SLEW_DIV_MIN) - 1)
    else $error("skip enabled too early");
  AST_DIS_SKIP: assert property (skip_enable |-> !slave_driver_disable_n)
    else $error("skip with drivers enabled");

  COV_DIS: cover property ($fell(slave_driver_disable_n));
  COV_SKIP: cover property ($rose(skip_enable));
  COV_FAULT: cover property ($rose(fault_latched));
endmodule

bind cvms_core cvms_core_properties #(.SKIP_WAIT(SKIP_WAIT), .OV_DETECT(OV_DETECT)) u_props (
  .clk(clk), .rst(rst), .system_power_good(system_power_good), .shutdown_n(shutdown_n),
  .shutdown_high_voltage(shutdown_high_voltage), .fault_in(fault_in),
  .voltage_code(voltage_code), .slave_driver_disable_n(slave_driver_disable_n),
  .skip_enable(skip_enable), .low_side_gate(low_side_gate), .fault_latched(fault_latched)
);

// *** bench/cvms_cpu_model.sv ***
// Processor and power-good side driving the sequencer control pins.
// Assumes bench requests change right after a rising clk edge.
`timescale 1ns/10ps
module cvms_cpu_model (
  input  wire logic       clk,
  input  wire logic [5:0] want_code,
  input  wire logic       want_susp,
  input  wire logic       want_dps_n,
  input  wire logic       want_pg,
  input  wire logic       want_sd_n,
  output logic [5:0]      cpu_voltage_code = 6'h00,
  output logic            suspend_req = 1'b0,
  output logic            deep_sleep_req_n = 1'b1,
  output logic            system_power_good = 1'b1,
  output logic            shutdown_n = 1'b1
);
  // ==========
  // Pin drivers, all bits driven at all times
  always @(posedge clk)
  begin
    cpu_voltage_code <= want_code;
    suspend_req <= want_susp;
    deep_sleep_req_n <= want_dps_n;
    system_power_good <= want_pg;
    shutdown_n <= want_sd_n;
  end
endmodule

// *** bench/tb_cvms_core.sv ***
// Self-checking bench of the voltage mode sequencer core.
// Assumes the checker is bound and the CPU model is compiled alongside.
`timescale 1ns/10ps
module tb_cvms_core;
  // ==========
  // Signals
  localparam int DW = 4;
  localparam int SW = 3;
  localparam int TK = 31;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] code_c = 6'h00;
  logic susp_c = 1'b0;
  logic dps_c = 1'b1;
  logic pg_c = 1'b1;
  logic sd_c = 1'b1;
  logic boot = 1'b0;
  logic shv = 1'b0;
  logic [5:0] offs = 6'h00;
  cvms_pkg::cvms_sel_t ssel = '0;
  cvms_pkg::cvms_sel_t bsel = '0;
  cvms_pkg::cvms_fault_in_t fin = '0;
  logic [31:0] rdata;
  logic [5:0] code_m, vcode;
  logic susp_m, dps_m, pg_m, sd_m, dis_n, skip, lsg, flt, irq;
  int err_total = 0;
  int num_checks = 0;
  int n;
  int q[$];

  always #25 clk = ~clk;

  cvms_core #(.DIS_WAIT(DW), .SKIP_WAIT(SW), .OV_DETECT(1'b1)) uut (
    .clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr),
    .reg_read(rd), .reg_rdata(rdata), .cpu_voltage_code(code_m), .suspend_req(susp_m),
    .boot_mode(boot), .deep_sleep_req_n(dps_m), .deep_sleep_offset(offs),
    .suspend_level_sel(ssel), .boot_level_sel(bsel), .system_power_good(pg_m),
    .shutdown_n(sd_m), .shutdown_high_voltage(shv), .fault_in(fin), .voltage_code(vcode),
    .slave_driver_disable_n(dis_n), .skip_enable(skip), .low_side_gate(lsg),
    .fault_latched(flt), .irq(irq));
  cvms_cpu_model u_cpu (.clk(clk), .want_code(code_c), .want_susp(susp_c), .want_dps_n(dps_c),
    .want_pg(pg_c), .want_sd_n(sd_c), .cpu_voltage_code(code_m), .suspend_req(susp_m),
    .deep_sleep_req_n(dps_m), .system_power_good(pg_m), .shutdown_n(sd_m));

  // ==========
  // Reference model and tasks
  function automatic int exp_tgt();
    int t;
    t = boot ? int'(bsel) : (susp_c ? int'(ssel) : int'(code_c));
    if (!dps_c)
      t = t + int'($signed(offs));
    return (t < 0) ? 0 : ((t > 63) ? 63 : t);
  endfunction

  function automatic logic [5:0] sel(int w);
    case (w)
      0: return vcode;
      1: return {5'h00, dis_n};
      2: return {5'h00, skip};
      default: return {5'h00, lsg};
    endcase
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wt(int w, logic [5:0] v);
    logic [5:0] tg;
    n = 2;
    repeat (2) @(posedge clk);
    tg = (w == 0) ? 6'(exp_tgt()) : v;
    #1;
    while (sel(w) !== tg)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > 5000)
      begin
        err_total++;
        final_report();
      end
    end
    @(posedge clk);
  endtask

  task automatic wreg(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rc(logic [3:0] a, logic [31:0] e, logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk("reg", e & m, rdata & m);
  endtask

  // ==========
  // Main sequence
  initial
  begin
    void'($urandom(51));
    repeat (5) @(posedge clk);
    chk("lsg_rst", 1, lsg);
    chk("dis_rst", 1, dis_n);
    rst <= 1'b0;
    rc(cvms_pkg::OFS_CTRL, 32'(cvms_pkg::SLEW_DIV_RST), 32'h0000_01FF);
    wreg(cvms_pkg::OFS_CTRL, 32'h0000_0005);
    rc(cvms_pkg::OFS_CTRL, 32'(cvms_pkg::SLEW_DIV_MIN), 32'h0000_01FF);
    wreg(cvms_pkg::OFS_CTRL, 32'h0000_01FF);
    rc(cvms_pkg::OFS_CTRL, 32'(cvms_pkg::SLEW_DIV_MAX), 32'h0000_01FF);
    wreg(cvms_pkg::OFS_CTRL, 32'h0000_001F);
    rc(4'h2, 32'h0000_0000, 32'hFFFF_FFFF);
    rc(cvms_pkg::OFS_MASK, 32'h0000_0000, 32'h0000_000F);
    q = {63, 0, int'($urandom_range(62, 1))};
    foreach (q[i])
    begin
      code_c <= 6'(q[i]);
      wt(0, 6'h00);
      chk("code", exp_tgt(), vcode);
    end
    ssel <= cvms_pkg::cvms_sel_t'(code_c ^ 6'($urandom_range(63, 1)));
    susp_c <= 1'b1;
    wt(0, 6'h00);
    chk("susp_code", exp_tgt(), vcode);
    wt(1, 6'h00);
    chk("dis_time", 1, n >= DW * TK - 3 && n <= DW * TK + 3);
    wt(2, 6'h01);
    chk("skip_time", 1, n >= SW * TK - 3 && n <= SW * TK + 3);
    chk("irq_masked", 0, irq);
    wreg(cvms_pkg::OFS_MASK, 32'h0000_0002);
    rc(cvms_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
    chk("irq_set", 1, irq);
    wreg(cvms_pkg::OFS_STATUS, 32'h0000_0002);
    rc(cvms_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0002);
    chk("irq_clr", 0, irq);
    bsel <= cvms_pkg::cvms_sel_t'(ssel ^ 6'h2A);
    boot <= 1'b1;
    repeat (3) @(posedge clk);
    chk("dis_back", 1, dis_n);
    chk("skip_off", 0, skip);
    wt(0, 6'h00);
    chk("boot_code", exp_tgt(), vcode);
    susp_c <= 1'b0;
    dps_c <= 1'b0;
    code_c <= vcode ^ 6'h20;
    offs <= 6'(33 + $urandom_range(62));
    @(posedge clk);
    boot <= 1'b0;
    wt(0, 6'h00);
    chk("dps_code", exp_tgt(), vcode);
    wt(1, 6'h00);
    chk("dps_dis", 1, n >= DW * TK - 3 && n <= DW * TK + 3);
    dps_c <= 1'b1;
    code_c <= 6'h28;
    wt(0, 6'h00);
    sd_c <= 1'b0;
    repeat (40) @(posedge clk);
    chk("ramp", 1, vcode inside {6'h26, 6'h27});
    wt(3, 6'h01);
    chk("off_code", 0, vcode);
    sd_c <= 1'b1;
    wt(3, 6'h00);
    pg_c <= 1'b0;
    repeat (3) @(posedge clk);
    chk("pg_flt", 1, flt);
    chk("flt_lsg", 1, lsg);
    pg_c <= 1'b1;
    repeat (5) @(posedge clk);
    chk("flt_hold", 1, flt);
    rc(cvms_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
    rc(cvms_pkg::OFS_STATE, 32'h0000_6740, 32'hFFFF_FFFF);
    sd_c <= 1'b0;
    repeat (3) @(posedge clk);
    chk("flt_clr", 0, flt);
    sd_c <= 1'b1;
    wt(3, 6'h00);
    for (int k = 0; k < 3; k++)
    begin
      fin <= cvms_pkg::cvms_fault_in_t'(3'(1 << k));
      repeat (2) @(posedge clk);
      chk("fault_in", 1, flt);
      fin <= '0;
      shv <= 1'b1;
      repeat (2) @(posedge clk);
      chk("shv_clr", 0, flt);
      shv <= 1'b0;
      wt(3, 6'h00);
    end
    final_report();
  end
endmodule
